// ---- ssb_pkg.sv ----
/*
  Package for the burst address and sleep control block: widths, sleep
  timing, command and state types.
  Assumes a single 25 MHz clock.
*/
`default_nettype none
package ssb_pkg;
  localparam int ADDR_W = 18;
  localparam int CLK_NS = 40;
  // Sleep entry delay in clock cycles after the request is seen
  localparam logic [1:0] SLEEP_ENTRY_CYCLES = 2'h2;
  // Recovery time after sleep, in ns, and its cycle count (rounded up)
  localparam int SLEEP_RECOVERY_NS = 100;
  localparam int SLEEP_RECOVERY_CYC_I =
    (SLEEP_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SLEEP_RECOVERY_CYC =
    (SLEEP_RECOVERY_CYC_I < 1) ? 8'h01 : 8'(SLEEP_RECOVERY_CYC_I);
  localparam logic [1:0] BURST_LEN_M1 = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST = '0;
  localparam logic [1:0] CNT_RST = 2'h0;

  typedef enum logic [1:0] {
    SSB_CMD_DESELECT,
    SSB_CMD_READ,
    SSB_CMD_WRITE
  } ssb_cmd_type;

  typedef enum logic [1:0] {
    SSB_ACTIVE,
    SSB_ENTERING,
    SSB_ASLEEP,
    SSB_RECOVER
  } ssb_sleep_type;

  // Bus request sampled each clock edge
  typedef struct packed {
    logic              advance_load_select;
    ssb_cmd_type       cmd;
    logic [ADDR_W-1:0] addr;
  } ssb_req_type;

  // Access presented to the array
  typedef struct packed {
    logic              valid;
    ssb_cmd_type       cmd;
    logic [ADDR_W-1:0] addr;
  } ssb_acc_type;
endpackage
`default_nettype wire

// ---- ssb_sync3.sv ----
/*
  Three-flop input synchroniser; a change counts once the second and third
  flops agree.
  Assumes the input is asynchronous to i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ssb_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic lvl_nxt;

  // Accept the new level only when stages two and three agree
  always_comb begin
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  end

  // Register the chain
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_r  <= RST_VAL;
      s2_r  <= RST_VAL;
      s3_r  <= RST_VAL;
      lvl_r <= RST_VAL;
    end else begin
      s1_r  <= i_async;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;
endmodule
`default_nettype wire

// ---- ssb_ctrl.sv ----
/*
  Burst address generation, mode pin selection and sleep control of a
  synchronous no-turnaround SRAM.
  Assumes a controller on the same clock drives the request each edge; the
  mode and sleep pins are asynchronous and are synchronised here.
*/
// How it works
// RL1 - Advance high steps the burst counter and uses the counted address.
// RL2 - A burst starts with advance low, loading the external address.
// RL3 - After four accesses the counter wraps; fifth access repeats the first.
// RL4 - Order select low: low bits count up by one modulo four.
// RL5 - Order select high: low bits are start XOR counter.
// RL6 - Flow-through select low gives flow-through, high gives pipelined.
// RL7 - Unconnected mode pins default to pipelined, active operation.
// RL8 - Controller keeps sleep request low for normal operation.
// RL9 - Sleep request is asynchronous, active high; standby while high.
// RL10 - Sleep is entered two cycles after the request, state kept.
// RL11 - Asleep, every input but sleep is ignored; data outputs float.
// RL12 - Controller raises sleep only after pending operations finish.
// RL13 - After sleep, only deselect or read until recovery time passes.
// RL14 - Reads and writes follow back to back with no turnaround.
// RL15 - Clock-gate high ignores the edge and holds all state; here the sleep state, its timer and the synchronisers advance and the violation flag clears.
// RL16 - Two-bit counter advances on every continue cycle of any kind.
// RL17 - Address bits above the two lowest keep their loaded value.
`timescale 1ns/1ps
`default_nettype none
module ssb_ctrl (
  input  wire logic                   i_clock,
  input  wire logic                   i_reset_n,
  input  wire ssb_pkg::ssb_req_type   i_req,
  input  wire logic                   i_clock_gate,
  input  wire logic                   i_burst_order_select,
  input  wire logic                   i_flow_through_select,
  input  wire logic                   i_sleep_request,
  output ssb_pkg::ssb_acc_type        o_access,
  output logic                        o_pipelined,
  output logic                        o_asleep,
  output logic                        o_recovering,
  output logic                        o_data_oe_n,
  output logic                        o_cmd_violation
);
  localparam int AW = ssb_pkg::ADDR_W;

  logic                  sleep_lvl;
  logic                  ft_lvl;
  logic                  order_lvl;
  logic [AW-1:0]         base_r;
  logic [AW-1:0]         base_nxt;
  logic [1:0]            cnt_r;
  logic [1:0]            cnt_nxt;
  logic                  burst_r;
  logic                  burst_nxt;
  ssb_pkg::ssb_acc_type  acc_r;
  ssb_pkg::ssb_acc_type  acc_nxt;
  ssb_pkg::ssb_cmd_type  bcmd_r;
  ssb_pkg::ssb_cmd_type  bcmd_nxt;
  ssb_pkg::ssb_sleep_type st_r;
  ssb_pkg::ssb_sleep_type st_nxt;
  logic [7:0]            tmr_r;
  logic [7:0]            tmr_nxt;
  logic                  pipe_r;
  logic                  pipe_nxt;
  logic                  oe_n_r;
  logic                  oe_n_nxt;
  logic                  viol_r;
  logic                  viol_nxt;
  logic [1:0]            low_bits;
  logic                  running;
  logic                  asleep_r;
  logic                  asleep_nxt;
  logic                  recov_r;
  logic                  recov_nxt;

  // Asynchronous sleep and mode pins; pins default as if pulled [RL7]
  ssb_sync3 #(.RST_VAL(1'b0)) u_sleep_sync (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_async   (i_sleep_request),
    .o_level   (sleep_lvl)
  );
  ssb_sync3 #(.RST_VAL(1'b1)) u_ft_sync (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_async   (i_flow_through_select),
    .o_level   (ft_lvl)
  );
  ssb_sync3 #(.RST_VAL(1'b0)) u_order_sync (
    .i_clock   (i_clock),
    .i_reset_n (i_reset_n),
    .i_async   (i_burst_order_select),
    .o_level   (order_lvl)
  );

  // Sleep state: entry delay, standby, recovery window
  always_comb begin
    st_nxt  = st_r;
    tmr_nxt = tmr_r;
    unique case (st_r)
      ssb_pkg::SSB_ACTIVE: begin
        if (sleep_lvl) begin
          // The edge that leaves ACTIVE is the first of the entry cycles
          st_nxt  = ssb_pkg::SSB_ENTERING;
          tmr_nxt = 8'(ssb_pkg::SLEEP_ENTRY_CYCLES) - 8'h02;
        end
      end
      ssb_pkg::SSB_ENTERING: begin
        if (tmr_r == 8'h00) begin
          st_nxt = ssb_pkg::SSB_ASLEEP;                        // [RL10]
        end else begin
          tmr_nxt = tmr_r - 8'h01;
        end
      end
      ssb_pkg::SSB_ASLEEP: begin
        if (!sleep_lvl) begin                                  // [RL9]
          st_nxt  = ssb_pkg::SSB_RECOVER;
          tmr_nxt = ssb_pkg::SLEEP_RECOVERY_CYC;
        end
      end
      ssb_pkg::SSB_RECOVER: begin
        if (sleep_lvl) begin
          st_nxt  = ssb_pkg::SSB_ENTERING;
          tmr_nxt = 8'(ssb_pkg::SLEEP_ENTRY_CYCLES) - 8'h02;
        end else if (tmr_r <= 8'h01) begin
          st_nxt  = ssb_pkg::SSB_ACTIVE;
          tmr_nxt = 8'h00;
        end else begin
          tmr_nxt = tmr_r - 8'h01;
        end
      end
    endcase
    // Status flags registered so the outputs come from flops
    asleep_nxt = (st_nxt == ssb_pkg::SSB_ASLEEP);
    recov_nxt  = (st_nxt == ssb_pkg::SSB_RECOVER);
  end

  // Requests are taken when not asleep and the edge is not gated
  assign running = (st_r != ssb_pkg::SSB_ASLEEP) &&
                   !i_clock_gate;                      // [RL11] [RL15]

  // Low address bits from loaded start and counter
  always_comb begin
    if (order_lvl) begin
      low_bits = base_r[1:0] ^ cnt_nxt;                        // [RL5]
    end else begin
      low_bits = base_r[1:0] + cnt_nxt;                        // [RL4]
    end
  end

  // Burst counter, loaded address and access output
  always_comb begin
    base_nxt  = base_r;
    cnt_nxt   = cnt_r;
    burst_nxt = burst_r;
    bcmd_nxt  = bcmd_r;
    acc_nxt   = acc_r;
    pipe_nxt  = pipe_r;
    oe_n_nxt  = oe_n_r;
    viol_nxt  = 1'b0;
    if (st_r == ssb_pkg::SSB_ASLEEP) begin
      acc_nxt.valid = 1'b0;
      oe_n_nxt      = 1'b1;                                    // [RL11]
    end else if (running) begin
      pipe_nxt = ft_lvl;                                       // [RL6]
      if (!i_req.advance_load_select) begin
        // Load a new start address and command [RL2]
        base_nxt  = i_req.addr;
        cnt_nxt   = ssb_pkg::CNT_RST;
        bcmd_nxt  = i_req.cmd;
        burst_nxt = (i_req.cmd != ssb_pkg::SSB_CMD_DESELECT);
        acc_nxt.valid = burst_nxt;
        acc_nxt.cmd   = i_req.cmd;                             // [RL14]
        acc_nxt.addr  = i_req.addr;
        viol_nxt = (st_r == ssb_pkg::SSB_RECOVER) &&
                   (i_req.cmd == ssb_pkg::SSB_CMD_WRITE);      // [RL13]
      end else begin
        // Continue: count wraps after four accesses [RL1] [RL3] [RL16]
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == ssb_pkg::BURST_LEN_M1) begin
          cnt_nxt = ssb_pkg::CNT_RST;
        end
        acc_nxt.valid = burst_r;
        acc_nxt.cmd   = burst_r ? i_req.cmd : ssb_pkg::SSB_CMD_DESELECT;
        acc_nxt.addr  = {base_r[AW-1:2], low_bits};            // [RL17]
        viol_nxt = (st_r == ssb_pkg::SSB_RECOVER) && burst_r &&
                   (i_req.cmd == ssb_pkg::SSB_CMD_WRITE);      // [RL13]
      end
      oe_n_nxt = !(acc_nxt.valid &&
                   acc_nxt.cmd == ssb_pkg::SSB_CMD_READ);
    end
  end

  // Register all state
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r    <= ssb_pkg::SSB_ACTIVE;
      tmr_r   <= 8'h00;
      base_r  <= ssb_pkg::ADDR_RST;
      cnt_r   <= ssb_pkg::CNT_RST;
      burst_r <= 1'b0;
      bcmd_r  <= ssb_pkg::SSB_CMD_DESELECT;
      acc_r   <= '0;
      pipe_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      viol_r  <= 1'b0;
      asleep_r <= 1'b0;
      recov_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      tmr_r   <= tmr_nxt;
      base_r  <= base_nxt;
      cnt_r   <= cnt_nxt;
      burst_r <= burst_nxt;
      bcmd_r  <= bcmd_nxt;
      acc_r   <= acc_nxt;
      pipe_r  <= pipe_nxt;
      oe_n_r  <= oe_n_nxt;
      viol_r  <= viol_nxt;
      asleep_r <= asleep_nxt;
      recov_r  <= recov_nxt;
    end
  end

  assign o_access        = acc_r;
  assign o_pipelined     = pipe_r;
  assign o_asleep        = asleep_r;
  assign o_recovering    = recov_r;
  assign o_data_oe_n     = oe_n_r;
  assign o_cmd_violation = viol_r;
endmodule
`default_nettype wire

// ---- ssb_ctrl_monitor.sv ----
/* Port checker for ssb_ctrl.
   Assumes one clock and an async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module ssb_ctrl_monitor (
  input wire logic                 i_clock,
  input wire logic                 i_reset_n,
  input wire ssb_pkg::ssb_req_type i_req,
  input wire logic                 i_clock_gate,
  input wire logic                 i_sleep_request,
  input wire ssb_pkg::ssb_acc_type o_access,
  input wire logic                 o_asleep,
  input wire logic                 o_recovering,
  input wire logic                 o_data_oe_n,
  input wire logic                 o_cmd_violation
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Taken edge, and a taken load of a read or write
  wire logic tk = !o_asleep && !i_clock_gate;
  wire logic ld = tk && !i_req.advance_load_select && |i_req.cmd;
  a_load_addr: assert property (ld |=> o_asleep ||
    o_access.valid && o_access.addr == $past(i_req.addr)) else $error("load");
  a_burst_wrap: assert property (
    ld ##1 (tk && i_req.advance_load_select)[*4] |=>
    o_asleep || o_access.addr == $past(i_req.addr, 5)) else $error("wrap");
  a_gate_hold: assert property (i_clock_gate && !o_asleep |=>
    o_asleep || $stable(o_access)) else $error("gate");
  a_sleep_float: assert property (o_asleep && $past(o_asleep) |->
    o_data_oe_n && !o_access.valid) else $error("float");
  a_sleep_entry: assert property ($rose(i_sleep_request) &&
    !o_asleep && !o_recovering |-> (!o_asleep)[*4] ##[1:4] o_asleep)
    else $error("entry");
  a_recover_len: assert property ($fell(o_asleep) |->
    o_recovering[*3] ##1 !o_recovering) else $error("recover");
  // A continue writes only inside a live burst, seen as a valid access
  a_write_flag: assert property (tk && o_recovering &&
    i_req.cmd == ssb_pkg::SSB_CMD_WRITE &&
    (!i_req.advance_load_select || o_access.valid) |=> o_cmd_violation)
    else $error("flag");
  a_flag_quiet: assert property (!o_recovering |=> !o_cmd_violation)
    else $error("quiet");
  c_wrap: cover property (ld ##1 (tk && i_req.advance_load_select)[*4]);
  c_sleep: cover property ($fell(o_asleep));
  c_flag: cover property (o_cmd_violation);
endmodule
`default_nettype wire

// ---- ssb_host_model.sv ----
/* Host model: one load then four continues per go.
   Assumes the bench drives the wait-state input. */
`timescale 1ns/1ps
`default_nettype none
module ssb_host_model (
  input  wire logic                       i_clock,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_go,
  input  wire logic                       i_gate,
  input  wire ssb_pkg::ssb_cmd_type       i_cmd,
  input  wire logic [ssb_pkg::ADDR_W-1:0] i_addr,
  output ssb_pkg::ssb_req_type            o_req,
  output logic                            o_load
);
  logic [2:0] beat_r;
  // Requests move only on ungated edges; address toggles when unused
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      beat_r <= 3'h0;
      o_req  <= '0;
      o_load <= 1'b0;
    end else begin
      o_load <= !i_gate && i_go && beat_r == 3'h0;
      if (!i_gate) begin
        if (beat_r != 3'h0) begin
          o_req.advance_load_select <= 1'b1;
          o_req.addr <= ~o_req.addr;
          beat_r <= beat_r - 3'h1;
        end else if (i_go) begin
          o_req  <= '{1'b0, i_cmd, i_addr};
          beat_r <= 3'h4;
        end else begin
          o_req.advance_load_select <= 1'b0;
          o_req.cmd <= ssb_pkg::SSB_CMD_DESELECT;
          o_req.addr <= ~o_req.addr;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
/* Bench for ssb_ctrl: random bursts, wait states, mode pin, sleep.
   Assumes the host model and the port checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int AW = ssb_pkg::ADDR_W;
  logic                 i_clock, i_reset_n, gate, ord, ft, slp, go, rnd, ld;
  logic                 pipe, asl, rec, oe_n, viol, took, vq, live;
  logic                 hold, rgate;
  logic [1:0]           cnt;
  logic [AW-1:0]        adr, st;
  ssb_pkg::ssb_cmd_type cmd;
  ssb_pkg::ssb_req_type req;
  ssb_pkg::ssb_acc_type acc, eq;
  int                   n_fail, samples_checked;
  ssb_ctrl dut (.i_clock, .i_reset_n, .i_req(req), .i_clock_gate(gate),
    .i_burst_order_select(ord), .i_flow_through_select(ft),
    .i_sleep_request(slp), .o_access(acc), .o_pipelined(pipe),
    .o_asleep(asl), .o_recovering(rec), .o_data_oe_n(oe_n),
    .o_cmd_violation(viol));
  ssb_host_model host (.i_clock, .i_reset_n, .i_go(go), .i_gate(gate),
    .i_cmd(cmd), .i_addr(adr), .o_req(req), .o_load(ld));
  task automatic check(input logic [31:0] s, input logic [31:0] w);
    samples_checked++;
    if (s !== w) begin
      n_fail++;
      $display("[FAIL] %0t seen=%h want=%h", $time, s, w);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d fails=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [AW-1:0] baddr(input logic [AW-1:0] s,
      input logic [1:0] k);
    baddr = {s[AW-1:2], ord ? s[1:0] ^ k : s[1:0] + k};
  endfunction
  // Predict each taken access and compare it one edge later
  always @(posedge i_clock) if (i_reset_n) begin
    if (took) begin
      check(eq.valid ? acc : acc.valid, eq);
      check(oe_n, !(eq.valid && eq.cmd == ssb_pkg::SSB_CMD_READ));
      check(viol, vq);
    end
    took = !gate && !asl;
    vq = rec && req.cmd == ssb_pkg::SSB_CMD_WRITE &&
         (!req.advance_load_select || live);
    if (took && !req.advance_load_select) begin
      st = req.addr;
      cnt = 2'h0;
      live = |req.cmd;
    end else if (took) cnt++;
    eq = live ? {1'b1, req.cmd, baddr(st, cnt)} : '0;
  end
  // Random wait states while rnd is high; hold forces them on
  always @(posedge i_clock) rgate <= $urandom_range(3) == 0;
  assign gate = hold || (rnd && rgate);
  task automatic burst(input logic [1:0] c, input logic [AW-1:0] a);
    int k;
    cmd <= ssb_pkg::ssb_cmd_type'(c);
    adr <= a;
    go <= 1'b1;
    k = 0;
    do @(posedge i_clock); while (!ld && ++k < 40);
    if (k >= 40) n_fail++; // Load never issued
  endtask
  task automatic nap(input logic [1:0] c, input int n);
    int k;
    burst(c, AW'($urandom));
    go <= 1'b0;
    repeat (n) @(posedge i_clock);
    hold <= 1'b1;
    slp <= 1'b1;
    repeat (12) @(posedge i_clock);
    check(asl, 1'b1);
    check(oe_n, 1'b1);
    slp <= 1'b0;
    k = 0;
    do @(posedge i_clock); while (!rec && ++k < 20);
    if (k >= 20) n_fail++; // Recovery never seen
    hold <= 1'b0;
    repeat (8) @(posedge i_clock);
  endtask
  // Clock and watchdog
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  initial begin
    #100000;
    n_fail++;
    stop_test;
  end
  // Main sequence
  initial begin
    {i_reset_n, hold, ord, slp, go, rnd, took, live} = '0;
    ft = 1'b1;
    cmd = ssb_pkg::SSB_CMD_DESELECT;
    adr = '0;
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(32'h646de403));
    repeat (16) @(posedge i_clock);
    i_reset_n <= 1'b1;
    check(pipe, 1'b1);
    for (int o = 0; o < 2; o++) begin
      ord <= o[0];
      repeat (6) @(posedge i_clock);
      rnd <= 1'b1;
      burst(2'h1, '1);
      burst(2'h2, '0);
      repeat (30) burst(2'($urandom_range(2)), AW'($urandom));
      rnd <= 1'b0;
      go <= 1'b0;
      @(posedge i_clock);
      hold <= 1'b0;
      repeat (12) @(posedge i_clock);
    end
    nap(2'h1, 2);
    nap(2'h2, 0);
    for (int f = 0; f < 2; f++) begin
      ft <= f[0];
      repeat (6) @(posedge i_clock);
      check(pipe, f[0]);
    end
    stop_test;
  end
endmodule
bind ssb_ctrl ssb_ctrl_monitor mon (.i_clock, .i_reset_n, .i_req,
  .i_clock_gate, .i_sleep_request, .o_access, .o_asleep, .o_recovering,
  .o_data_oe_n, .o_cmd_violation);
`default_nettype wire
